/* design/bfd_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 16-bit registers on a plain address/strobe port
// Notes:   Definitions only
`ifndef BFD_CFG_SVH
`define BFD_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BFD_ADDR_W 10
`define BFD_OFS_OUT5_LEVEL 10'h1_CC
`define BFD_OFS_SUPPLY_SEL 10'h2_88
`define BFD_OFS_SHORT_LEVEL 10'h2_8A
`define BFD_OFS_STATE_MON 10'h2_A4
`define BFD_OFS_DUTY_MON 10'h2_A6
`define BFD_OFS_IRQ_STATUS 10'h3_00
`define BFD_OFS_IRQ_ENABLE 10'h3_02
`define BFD_OFS_IRQ_CLEAR 10'h3_04

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BFD_RST_OUT5_LEVEL 16'h0_FFF
`define BFD_RST_SUPPLY_SEL 16'h0_1C0
`define BFD_RST_SHORT_LEVEL 16'h2_882

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BFD_LEVEL_MSB 11
`define BFD_SHORT_OFF_BIT 15
`define BFD_SUPPLY_MSB 15
`define BFD_SUPPLY_LSB 10
`define BFD_THR_MSB 11
`define BFD_THR_LSB 9
`define BFD_STATE_MSB 4

// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define BFD_IRQ_W 3
`define BFD_IRQ_SHORT 0
`define BFD_IRQ_STATE 1
`define BFD_IRQ_DUTY 2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BFD_CLK_MHZ 200
`define BFD_DUTY_WIN_US 10
`define BFD_DUTY_WIN_CYC (`BFD_DUTY_WIN_US * `BFD_CLK_MHZ)

`endif

/* design/bfd_duty_meter.sv */
// Purpose: Measures the duty cycle of the brightness input
// Assumes: Input already synchronised to clk
// Notes:   Result is high time over a fixed window, scaled to 16 bits
`timescale 1ns/1ps
`include "bfd_cfg.svh"
module bfd_duty_meter
    import bfd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pwm_in,
    output logic [15:0] duty_code,
    output logic duty_update
);
    localparam int WIN = `BFD_DUTY_WIN_CYC;
    logic [15:0] win_cnt_ff;
    logic [15:0] nxt_win_cnt;
    logic [15:0] high_cnt_ff;
    logic [15:0] nxt_high_cnt;
    logic [15:0] duty_ff;
    logic [15:0] nxt_duty;
    logic upd_ff;
    logic nxt_upd;
    logic [31:0] scaled;

    always_comb begin
        nxt_win_cnt = win_cnt_ff + 16'h0_001;
        nxt_high_cnt = high_cnt_ff + {15'h0_000, pwm_in};
        nxt_duty = duty_ff;
        nxt_upd = 1'b0;
        scaled = ({16'h0_000, nxt_high_cnt} * 32'h0000_FFFF) / 32'(WIN);
        if (win_cnt_ff == 16'(WIN - 1)) begin
            nxt_win_cnt = 16'h0_000;
            nxt_high_cnt = 16'h0_000;
            nxt_duty = scaled[15:0];
            nxt_upd = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_cnt_ff <= 16'h0_000;
            high_cnt_ff <= 16'h0_000;
            duty_ff <= 16'h0_000;
            upd_ff <= 1'b0;
        end else begin
            win_cnt_ff <= nxt_win_cnt;
            high_cnt_ff <= nxt_high_cnt;
            duty_ff <= nxt_duty;
            upd_ff <= nxt_upd;
        end
    end

    assign duty_code = duty_ff;
    assign duty_update = upd_ff;
endmodule // bfd_duty_meter

/* design/bfd_pkg.sv */
// Purpose: Types shared by the diagnostics register bank
// Assumes: Nothing
// Notes:   Constants live in bfd_cfg.svh
package bfd_pkg;

    typedef enum logic [4:0] {
        BFD_ST_RESET = 5'h0_0,
        BFD_ST_REGULATOR = 5'h0_1,
        BFD_ST_NVM_READ = 5'h0_2,
        BFD_ST_STANDBY = 5'h0_3,
        BFD_ST_BOOST_FIRST = 5'h0_4,
        BFD_ST_BOOST_LAST = 5'h0_C,
        BFD_ST_NORMAL = 5'h0_D,
        BFD_ST_DISCHARGE = 5'h0_E,
        BFD_ST_SHUTDOWN = 5'h0_F,
        BFD_ST_ERROR_RESTORE = 5'h1_0,
        BFD_ST_ALL_FAILED = 5'h1_1
    } bfd_state_e;

    typedef logic [15:0] bfd_word_t;

endpackage

/* design/bfd_regs.sv */
// Purpose: Output 5 level, supply select, short threshold and diagnostics
// Assumes: Plain register port, read data one cycle after read strobe
// Notes:   Short compare results and live state come from analog/core
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "bfd_cfg.svh"

module bfd_regs
    import bfd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [9:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic driver_enable,
    input wire logic [5:0] short_above_thr,
    input wire logic [4:0] live_state_in,
    input wire logic pwm_pin,
    output logic [11:0] output5_sink_level,
    output logic output5_short_check_off,
    output logic [5:0] external_supply_select,
    output logic [2:0] short_detect_voltage_sel,
    output logic [5:0] short_fault,
    output logic irq
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic pwm_sync;
    logic [4:0] state_sync;
    logic [5:0] short_sync;
    logic drv_en_sync;

    bfd_sync2 u_sync_pwm (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(pwm_pin),
        .sync_out(pwm_sync)
    );
    bfd_sync2 u_sync_en (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(driver_enable),
        .sync_out(drv_en_sync)
    );
    for (genvar i = 0; i < 5; i++) begin : g_state_sync
        bfd_sync2 u_sync_st (
            .clk(clk),
            .arst_n(arst_n),
            .async_in(live_state_in[i]),
            .sync_out(state_sync[i])
        );
    end
    for (genvar i = 0; i < 6; i++) begin : g_short_sync
        bfd_sync2 u_sync_sh (
            .clk(clk),
            .arst_n(arst_n),
            .async_in(short_above_thr[i]),
            .sync_out(short_sync[i])
        );
    end

    // ------------------------------------------------------------------
    // Duty measurement
    // ------------------------------------------------------------------
    logic [15:0] duty_code;
    logic duty_update;

    bfd_duty_meter u_duty (
        .clk(clk),
        .arst_n(arst_n),
        .pwm_in(pwm_sync),
        .duty_code(duty_code),
        .duty_update(duty_update)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    bfd_word_t out5_ff, nxt_out5;
    bfd_word_t supply_ff, nxt_supply;
    bfd_word_t thr_ff, nxt_thr;
    logic [4:0] state_ff, nxt_state;
    logic [4:0] state_prev_ff, nxt_state_prev;
    bfd_word_t duty_ff, nxt_duty;
    logic [5:0] fault_ff, nxt_fault;
    logic [2:0] ists_ff, nxt_ists;
    logic [2:0] ien_ff, nxt_ien;
    bfd_word_t rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic [5:0] check_off;
    logic [2:0] events;
    logic [2:0] clr;

    always_comb begin
        check_off = 6'h00;
        check_off[5] = out5_ff[`BFD_SHORT_OFF_BIT];
        nxt_out5 = out5_ff;
        nxt_supply = supply_ff;
        nxt_thr = thr_ff;
        nxt_ien = ien_ff;
        clr = 3'h0;
        if (reg_wr) begin
            case (reg_addr)
                `BFD_OFS_OUT5_LEVEL: nxt_out5 = reg_wdata;
                `BFD_OFS_SUPPLY_SEL: nxt_supply = reg_wdata;
                `BFD_OFS_SHORT_LEVEL: nxt_thr = reg_wdata;
                `BFD_OFS_IRQ_ENABLE: nxt_ien = reg_wdata[2:0];
                `BFD_OFS_IRQ_CLEAR: clr = reg_wdata[2:0];
                default: ;
            endcase
        end
        nxt_state_prev = state_sync;
        nxt_state = (state_sync == state_prev_ff) ? state_sync : state_ff;
        nxt_duty = duty_update ? duty_code : duty_ff;
        nxt_fault = drv_en_sync ? (short_sync & ~check_off) : 6'h00;
        events[`BFD_IRQ_SHORT] = |(nxt_fault & ~fault_ff);
        events[`BFD_IRQ_STATE] = (nxt_state != state_ff);
        events[`BFD_IRQ_DUTY] = duty_update && (duty_code != duty_ff);
        nxt_ists = (ists_ff & ~clr) | events;
        nxt_irq = |(nxt_ists & nxt_ien);
        nxt_rdata = 16'h0_000;
        if (reg_rd) begin
            case (reg_addr)
                `BFD_OFS_OUT5_LEVEL: nxt_rdata = out5_ff;
                `BFD_OFS_SUPPLY_SEL: nxt_rdata = supply_ff;
                `BFD_OFS_SHORT_LEVEL: nxt_rdata = thr_ff;
                `BFD_OFS_STATE_MON: nxt_rdata = {11'h000, state_ff};
                `BFD_OFS_DUTY_MON: nxt_rdata = duty_ff;
                `BFD_OFS_IRQ_STATUS: nxt_rdata = {13'h0000, ists_ff};
                `BFD_OFS_IRQ_ENABLE: nxt_rdata = {13'h0000, ien_ff};
                default: nxt_rdata = 16'h0_000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out5_ff <= `BFD_RST_OUT5_LEVEL;
            supply_ff <= `BFD_RST_SUPPLY_SEL;
            thr_ff <= `BFD_RST_SHORT_LEVEL;
            state_ff <= 5'h00;
            state_prev_ff <= 5'h00;
            duty_ff <= 16'h0_000;
            fault_ff <= 6'h00;
            ists_ff <= 3'h0;
            ien_ff <= 3'h0;
            rdata_ff <= 16'h0_000;
            irq_ff <= 1'b0;
        end else begin
            out5_ff <= nxt_out5;
            supply_ff <= nxt_supply;
            thr_ff <= nxt_thr;
            state_ff <= nxt_state;
            state_prev_ff <= nxt_state_prev;
            duty_ff <= nxt_duty;
            fault_ff <= nxt_fault;
            ists_ff <= nxt_ists;
            ien_ff <= nxt_ien;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = rdata_ff;
    assign output5_sink_level = out5_ff[`BFD_LEVEL_MSB:0];
    assign output5_short_check_off = out5_ff[`BFD_SHORT_OFF_BIT];
    assign external_supply_select = supply_ff[`BFD_SUPPLY_MSB:`BFD_SUPPLY_LSB];
    assign short_detect_voltage_sel = thr_ff[`BFD_THR_MSB:`BFD_THR_LSB];
    assign short_fault = fault_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_rd_level;
        reg_rd && reg_addr == `BFD_OFS_OUT5_LEVEL;
    endsequence
    sequence s_wr_level;
        reg_wr && reg_addr == `BFD_OFS_OUT5_LEVEL;
    endsequence
    sequence s_wr_supply;
        reg_wr && reg_addr == `BFD_OFS_SUPPLY_SEL;
    endsequence
    sequence s_wr_thr;
        reg_wr && reg_addr == `BFD_OFS_SHORT_LEVEL;
    endsequence
    sequence s_rd_supply;
        reg_rd && reg_addr == `BFD_OFS_SUPPLY_SEL;
    endsequence
    sequence s_rd_thr;
        reg_rd && reg_addr == `BFD_OFS_SHORT_LEVEL;
    endsequence
    sequence s_rd_state;
        reg_rd && reg_addr == `BFD_OFS_STATE_MON;
    endsequence
    sequence s_rd_duty;
        reg_rd && reg_addr == `BFD_OFS_DUTY_MON;
    endsequence
    sequence s_short_seen;
        drv_en_sync && (short_sync & ~check_off) != 6'h00;
    endsequence

    a_level_readback: assert property (s_rd_level |=> reg_rdata == $past(out5_ff))
        else $error("level readback wrong");
    a_short_off_mask: assert property (output5_short_check_off |=> !short_fault[5])
        else $error("short flagged while check off");
    a_supply_field: assert property (
        s_wr_supply |=> external_supply_select == $past(reg_wdata[15:10])
    )
        else $error("supply select not written");
    a_supply_level: assert property (
        s_wr_supply |=> external_supply_select[5] == $past(reg_wdata[15])
    )
        else $error("supply select mismatch");
    a_supply_low: assert property (
        s_wr_supply |=> supply_ff[9:0] == $past(reg_wdata[9:0])
    )
        else $error("reserved supply bits lost");
    a_thr_write: assert property (
        s_wr_thr |=> short_detect_voltage_sel == $past(reg_wdata[11:9])
    )
        else $error("threshold not written");
    a_short_disabled: assert property (!drv_en_sync |=> short_fault == 6'h00)
        else $error("short flagged while disabled");
    a_thr_reset: assert property ($rose(arst_n) |-> thr_ff == 16'h2_882)
        else $error("threshold reset value wrong");
    a_state_read: assert property (
        s_rd_state |=> reg_rdata[15:5] == 11'h000
    )
        else $error("state monitor upper bits set");
    a_state_track: assert property (##1 $stable(state_sync) [*2] |-> state_ff == state_sync)
        else $error("live state not tracked");
    a_duty_load: assert property (duty_update |=> duty_ff == $past(duty_code))
        else $error("duty not captured");
    a_irq_level: assert property (|(ists_ff & ien_ff) |-> irq)
        else $error("interrupt not raised");
    a_level_write: assert property (
        s_wr_level |=> output5_sink_level == $past(reg_wdata[11:0])
    )
        else $error("level not written");
    a_off_write: assert property (
        s_wr_level |=> output5_short_check_off == $past(reg_wdata[15])
    )
        else $error("check off bit not written");
    a_level_reset: assert property ($rose(arst_n) |-> out5_ff == `BFD_RST_OUT5_LEVEL)
        else $error("level reset value wrong");
    a_supply_reset: assert property ($rose(arst_n) |-> supply_ff == `BFD_RST_SUPPLY_SEL)
        else $error("supply reset value wrong");
    a_code_reset: assert property ($rose(arst_n) |-> short_detect_voltage_sel == 3'h4)
        else $error("threshold code reset wrong");
    a_short_flag: assert property (
        s_short_seen |=> short_fault == $past(short_sync & ~check_off)
    )
        else $error("short fault not flagged");
    a_fault_event: assert property (events[`BFD_IRQ_SHORT] |=> ists_ff[`BFD_IRQ_SHORT])
        else $error("short event not latched");
    a_state_value: assert property (
        s_rd_state |=> reg_rdata[4:0] == $past(state_ff)
    )
        else $error("state monitor value wrong");
    a_state_follow: assert property ($stable(state_sync) |=> state_ff == $past(state_sync))
        else $error("settled state not taken");
    a_state_hold: assert property (!$stable(state_sync) |=> $stable(state_ff))
        else $error("state taken while changing");
    a_supply_readback: assert property (
        s_rd_supply |=> reg_rdata == $past(supply_ff)
    )
        else $error("supply readback wrong");
    a_thr_readback: assert property (
        s_rd_thr |=> reg_rdata == $past(thr_ff)
    )
        else $error("threshold readback wrong");
    a_duty_read: assert property (
        s_rd_duty |=> reg_rdata == $past(duty_ff)
    )
        else $error("duty readback wrong");
    a_duty_hold: assert property (
        !duty_update |=> duty_ff == $past(duty_ff)
    )
        else $error("duty changed outside window end");
    a_status_read: assert property (
        reg_rd && reg_addr == `BFD_OFS_IRQ_STATUS |=> reg_rdata[2:0] == $past(ists_ff)
    )
        else $error("status readback wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0_000)
        else $error("read data not cleared");
    a_irq_off: assert property (!(|(ists_ff & ien_ff)) |-> !irq)
        else $error("interrupt without enabled status");
endmodule // bfd_regs

/* design/bfd_sync2.sv */
// Purpose: Two-stage synchroniser for one level
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module bfd_sync2 (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic sync_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // bfd_sync2

/* verification/bfd_regs_tb.sv */
// Purpose: Self-checking bench for the diagnostics register bank
// Assumes: Plain register port, read data in the cycle after the read strobe
// Notes:   Reserved-bit model kept in a word array keyed by offset
`timescale 1ns/1ps
`include "bfd_cfg.svh"
module backlight_fault_diag_regs_tb_top
    import bfd_pkg::*;
();
    logic clk, arst_n, reg_wr, reg_rd, driver_enable, pwm_pin, pwm_run;
    logic [9:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val, exp_w;
    logic [5:0] short_above_thr, external_supply_select, short_fault, exp_f;
    logic [4:0] live_state_in;
    logic [11:0] output5_sink_level;
    logic output5_short_check_off, irq;
    logic [2:0] short_detect_voltage_sel;
    logic [1:0] pwm_cnt;
    logic [9:0] rw_addr[3] = '{`BFD_OFS_OUT5_LEVEL, `BFD_OFS_SUPPLY_SEL, `BFD_OFS_SHORT_LEVEL};
    logic [4:0] codes[11] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08, 5'h0C, 5'h0D, 5'h0E,
        5'h0F, 5'h10, 5'h11};
    logic [15:0] mdl[int];
    int fail_count, tests_run, seed, i;

    bfd_regs u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .driver_enable(driver_enable), .short_above_thr(short_above_thr),
        .live_state_in(live_state_in), .pwm_pin(pwm_pin),
        .output5_sink_level(output5_sink_level),
        .output5_short_check_off(output5_short_check_off),
        .external_supply_select(external_supply_select),
        .short_detect_voltage_sel(short_detect_voltage_sel), .short_fault(short_fault),
        .irq(irq));

    // ------------------------------------------------------------------
    // Clock, brightness input and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        pwm_cnt <= arst_n ? pwm_cnt + 2'd1 : 2'd0;
        pwm_pin <= pwm_run && (pwm_cnt == 2'd0);
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (mdl.exists(a)) mdl[a] = d;
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        chk("reg_rdata", exp, rd_val);
    endtask

    task automatic chk_fields();
        logic [15:0] m_lvl, m_sup, m_thr;
        m_lvl = mdl[`BFD_OFS_OUT5_LEVEL];
        m_sup = mdl[`BFD_OFS_SUPPLY_SEL];
        m_thr = mdl[`BFD_OFS_SHORT_LEVEL];
        chk("sink_level", {4'h0, m_lvl[11:0]}, {4'h0, output5_sink_level});
        chk("check_off", {15'h0, m_lvl[15]}, {15'h0, output5_short_check_off});
        chk("supply_sel", {10'h0, m_sup[15:10]}, {10'h0, external_supply_select});
        chk("thr_sel", {13'h0, m_thr[11:9]}, {13'h0, short_detect_voltage_sel});
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'he14e_bd4f;
        arst_n = 1'b0;
        {reg_wr, reg_rd, driver_enable, pwm_run} = 4'h0;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        short_above_thr = 6'h00;
        live_state_in = 5'h00;
        mdl[`BFD_OFS_OUT5_LEVEL] = 16'h0FFF;
        mdl[`BFD_OFS_SUPPLY_SEL] = 16'h01C0;
        mdl[`BFD_OFS_SHORT_LEVEL] = 16'h2882;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk_fields();
        chk("irq", 16'h0000, {15'h0, irq});
        rd_chk(`BFD_OFS_OUT5_LEVEL, 16'h0FFF);
        rd_chk(`BFD_OFS_SUPPLY_SEL, 16'h01C0);
        rd_chk(`BFD_OFS_SHORT_LEVEL, 16'h2882);
        rd_chk(`BFD_OFS_STATE_MON, 16'h0000);
        rd_chk(`BFD_OFS_DUTY_MON, 16'h0000);
        rd_chk(10'h3FE, 16'h0000);
        for (i = 0; i < 12; i++) begin
            exp_w = 16'($random(seed));
            case (i % 3)
                0: exp_w = {exp_w[15], 3'h0, exp_w[11:0]};
                1: exp_w = {exp_w[15:10], 10'h1C0};
                default: exp_w = {4'h2, exp_w[11:9], 9'h082};
            endcase
            wr(rw_addr[i % 3], exp_w);
            rd_chk(rw_addr[i % 3], mdl[rw_addr[i % 3]]);
            chk_fields();
        end
        wr(`BFD_OFS_SUPPLY_SEL, 16'h81C0);
        wr(`BFD_OFS_SHORT_LEVEL, 16'h2882);
        #1;
        chk_fields();
        wr(`BFD_OFS_STATE_MON, 16'hFFFF);
        rd_chk(`BFD_OFS_STATE_MON, 16'h0000);
        wr(`BFD_OFS_DUTY_MON, 16'hFFFF);
        rd_chk(`BFD_OFS_DUTY_MON, 16'h0000);
        // Short faults from driver enable, compare results and output 5 disable
        for (i = 0; i < 10; i++) begin
            exp_w = 16'($random(seed));
            wr(`BFD_OFS_OUT5_LEVEL, {exp_w[15], 3'h0, exp_w[11:0]});
            driver_enable <= exp_w[14];
            short_above_thr <= exp_w[5:0];
            repeat (5) @(posedge clk);
            #1;
            exp_f = exp_w[14] ? (exp_w[5:0] & ~{exp_w[15], 5'h00}) : 6'h00;
            chk("short_fault", {10'h0, exp_f}, {10'h0, short_fault});
        end
        driver_enable <= 1'b0;
        repeat (5) @(posedge clk);
        wr(`BFD_OFS_IRQ_CLEAR, 16'h0007);
        wr(`BFD_OFS_IRQ_ENABLE, 16'h0000);
        for (i = 0; i < 11; i++) begin
            live_state_in <= codes[i];
            repeat (5) @(posedge clk);
            rd_chk(`BFD_OFS_STATE_MON, {11'h0, codes[i]});
        end
        rd_chk(`BFD_OFS_IRQ_STATUS, 16'h0002);
        chk("irq", 16'h0000, {15'h0, irq});
        wr(`BFD_OFS_IRQ_ENABLE, 16'h0003);
        rd_chk(`BFD_OFS_IRQ_ENABLE, 16'h0003);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(`BFD_OFS_IRQ_CLEAR, 16'h0002);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 16'h0000, {15'h0, irq});
        rd_chk(`BFD_OFS_IRQ_STATUS, 16'h0000);
        driver_enable <= 1'b1;
        short_above_thr <= 6'h01;
        repeat (6) @(posedge clk);
        #1;
        chk("irq", 16'h0001, {15'h0, irq});
        rd_chk(`BFD_OFS_IRQ_STATUS, 16'h0001);
        driver_enable <= 1'b0;
        wr(`BFD_OFS_IRQ_CLEAR, 16'h0007);
        // Quarter duty on the brightness input, two whole windows
        pwm_run <= 1'b1;
        repeat (2 * `BFD_DUTY_WIN_CYC + 200) @(posedge clk);
        exp_w = 16'((`BFD_DUTY_WIN_CYC / 4) * 65535 / `BFD_DUTY_WIN_CYC);
        rd_chk(`BFD_OFS_DUTY_MON, exp_w);
        rd_chk(`BFD_OFS_IRQ_STATUS, 16'h0004);
        report_and_stop();
    end
endmodule // backlight_fault_diag_regs_tb_top
